// ==== tmr3_regs.svh ====
`ifndef TMR3_REGS_SVH
`define TMR3_REGS_SVH
// ==========================================
// register byte offsets
`define TMR3_OFS_MODE 8'h00
`define TMR3_OFS_CTRL 8'h04
`define TMR3_OFS_STAT 8'h08
`define TMR3_OFS_CSEL 8'h0c
`define TMR3_OFS_CM1 8'h10
`define TMR3_OFS_CM2 8'h14
`define TMR3_OFS_CO1 8'h18
`define TMR3_OFS_CO2 8'h1c
`define TMR3_OFS_CAP 8'h20
// ==========================================
// field positions
`define TMR3_CTL_RUN 0
`define TMR3_CTL_TS 1
`define TMR3_CTL_TOP 2
`define TMR3_CTL_EIM 3
`define TMR3_CM_IRQ 0
`define TMR3_CM_RST 1
`define TMR3_CM_TOG 2
`define TMR3_CM_SGL 3
`define TMR3_ST_C1 0
`define TMR3_ST_C2 1
`define TMR3_ST_ED 2
`define TMR3_ST_RUN 3
// ==========================================
// reset values and lowest legal mode code
`define TMR3_RST_MODE 4'hf
`define TMR3_RST_CSEL 4'hf
`define TMR3_RST_CM 4'h0
`define TMR3_RST_CTRL 4'h0
`define TMR3_RST_CO 8'hff
`define TMR3_MODE_MIN 4'h4
`endif

// ==== tmr3_pkg.sv ====
package tmr3_pkg;
    // ==========================================
    // operating modes, code 1111 is mode 1
    typedef enum logic [3:0] {
        TMR3_M1 = 4'b1111,
        TMR3_M2 = 4'b1110,
        TMR3_M3 = 4'b1101,
        TMR3_M4 = 4'b1100,
        TMR3_M5 = 4'b1011,
        TMR3_M6 = 4'b1010,
        TMR3_M7 = 4'b1001,
        TMR3_M8 = 4'b1000,
        TMR3_M9 = 4'b0111,
        TMR3_M10 = 4'b0110,
        TMR3_M11 = 4'b0101,
        TMR3_M12 = 4'b0100
    } tmr3_mode_t;
    // counter clock sources
    typedef enum logic [1:0] {
        TMR3_CK_EXT = 2'b00,
        TMR3_CK_T1 = 2'b01,
        TMR3_CK_T2 = 2'b10,
        TMR3_CK_SYS = 2'b11
    } tmr3_clk_t;
endpackage

// ==== tmr3_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_regs.svh"
// ==========================================
// input stage: synchroniser and edge decoder
module tmr3_edge (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    input wire logic [1:0] edge_sel_in,
    output logic level_out,
    output logic edge_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    // two-stage synchroniser plus history flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in; // RQ2
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign level_out = s2_ff;
    // select positive, negative or both edges
    always_comb begin
        unique case (edge_sel_in)
            2'b10: edge_out = s2_ff & ~s3_ff; // RQ25
            2'b01: edge_out = ~s2_ff & s3_ff; // RQ25
            2'b00: edge_out = s2_ff ^ s3_ff; // RQ25
            default: edge_out = 1'b0; // code 11 has no edge
        endcase
    end
endmodule
`default_nettype wire

// ==== tmr3_top.sv ====
// How it works
// RQ1 - 8-bit counter, two compares, readable capture
// RQ2 - external input synchronised to system clock
// RQ3 - match resets, interrupts or toggles per mask
// RQ4 - single action fires once per start
// RQ5 - compares alternate, starting with one
// RQ6 - after single action, other compare only
// RQ7 - control starts, stops, presets, edge mask
// RQ8 - clock select picks source and edge
// RQ9 - edge interrupt only when stopped and masked
// RQ10 - status register shows match and edge
// RQ11 - effective compare is value plus one
// RQ12 - mode 1 plain timer or counter
// RQ13 - mode 2 edge trigger, capture, restart
// RQ14 - mode 3 timer 2 toggle captures, resets
// RQ15 - modes 4, 5 output timer 2 signal
// RQ16 - mode 6 carrier gated by timer 2
// RQ17 - mode 7 carrier gated by serial data
// RQ18 - mode 8 serial data picks compare
// RQ19 - mode 9 pulse width, timer 2 restart
// RQ20 - mode 10 compare one shifts input bit
// RQ21 - mode 11 mid-frame edge flop shifted
// RQ22 - mode 12 edge captures counter
// RQ23 - mode codes 1111 to 0100, reset 1111
// RQ24 - status read clears the three flags
// RQ25 - edge select codes pos, neg, both
// RQ26 - clock source codes sys, t2, t1, ext
// RQ27 - stop clears counter and compare select
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_regs.svh"
module tmr3_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic external_timer_in,
    input wire logic second_timer_output_flipflop_in,
    input wire logic second_timer_out_in,
    input wire logic first_timer_out_in,
    input wire logic serial_data_in,
    output logic timer_output_pin_out,
    output logic timer_irq_out,
    output logic shift_clk_out,
    output logic shift_data_out
);
    // ==========================================
    // state
    tmr3_pkg::tmr3_mode_t mode_ff;
    logic run_ff, ts_ff, top_ff, eim_ff;
    logic [3:0] csel_ff, cm1_ff, cm2_ff;
    logic [7:0] co1_ff, co2_ff, cnt_ff, cap_ff;
    logic st_c1_ff, st_c2_ff, st_ed_ff;
    logic sel_ff, done1_ff, done2_ff, wait_ff, mid_ff, tog_ff;
    logic m2_prev_ff, t2_prev_ff, t1_prev_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    logic pin_ff, irq_ff, sclk_ff, sdat_ff;
    logic ext_lvl, ext_edge, tick, go, cur_sel, hit, hit1, hit2, t2tog;
    logic m_trig, m_t2trig, m_so, m_dem, restart, cap_evt, nxt_sel;
    logic wr, rd, st_rd, ctl_wr;
    logic [7:0] cmp_val;
    logic [3:0] cm_cur;
    logic [31:0] nxt_rdata;
    logic nxt_err;

    tmr3_edge u_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(external_timer_in),
        .edge_sel_in(csel_ff[3:2]), // RQ8
        .level_out(ext_lvl),
        .edge_out(ext_edge)
    );

    // ==========================================
    // apb slave, no wait state, read data registered in the setup cycle
    assign wr = psel_in & penable_in & pready_ff & pwrite_in;
    assign rd = psel_in & penable_in & pready_ff & ~pwrite_in;
    assign st_rd = rd & (paddr_in == `TMR3_OFS_STAT);
    assign ctl_wr = wr & (paddr_in == `TMR3_OFS_CTRL);

    // read mux and unmapped detection
    always_comb begin
        nxt_rdata = 32'h0;
        nxt_err = 1'b0;
        unique case (paddr_in)
            `TMR3_OFS_MODE: nxt_rdata[3:0] = mode_ff;
            `TMR3_OFS_CTRL: nxt_rdata[3:0] = {eim_ff, top_ff, ts_ff, run_ff};
            `TMR3_OFS_STAT: nxt_rdata[3:0] = {run_ff, st_ed_ff, st_c2_ff, st_c1_ff}; // RQ10
            `TMR3_OFS_CSEL: nxt_rdata[3:0] = csel_ff;
            `TMR3_OFS_CM1: nxt_rdata[3:0] = cm1_ff;
            `TMR3_OFS_CM2: nxt_rdata[3:0] = cm2_ff;
            `TMR3_OFS_CO1: nxt_rdata[7:0] = co1_ff;
            `TMR3_OFS_CO2: nxt_rdata[7:0] = co2_ff;
            `TMR3_OFS_CAP: nxt_rdata[7:0] = cap_ff; // RQ1
            default: nxt_err = 1'b1;
        endcase
    end

    // handshake flops
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel_in & ~penable_in & ~pready_ff;
            prdata_ff <= (psel_in & ~penable_in) ? nxt_rdata : 32'h0;
            pslverr_ff <= psel_in & ~penable_in & nxt_err;
        end
    end

    // ==========================================
    // software registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode_ff <= tmr3_pkg::TMR3_M1; // RQ23
            csel_ff <= `TMR3_RST_CSEL;
            cm1_ff <= `TMR3_RST_CM;
            cm2_ff <= `TMR3_RST_CM;
            co1_ff <= `TMR3_RST_CO;
            co2_ff <= `TMR3_RST_CO;
            {eim_ff, top_ff, ts_ff, run_ff} <= `TMR3_RST_CTRL;
        end else if (wr) begin
            unique case (paddr_in)
                `TMR3_OFS_MODE: begin
                    if (pwdata_in[3:0] >= `TMR3_MODE_MIN) begin // RQ23
                        mode_ff <= tmr3_pkg::tmr3_mode_t'(pwdata_in[3:0]);
                    end
                end
                `TMR3_OFS_CTRL: begin
                    run_ff <= pwdata_in[`TMR3_CTL_RUN]; // RQ7
                    ts_ff <= pwdata_in[`TMR3_CTL_TS];
                    top_ff <= pwdata_in[`TMR3_CTL_TOP];
                    eim_ff <= pwdata_in[`TMR3_CTL_EIM];
                end
                `TMR3_OFS_CSEL: csel_ff <= pwdata_in[3:0]; // RQ8
                `TMR3_OFS_CM1: cm1_ff <= pwdata_in[3:0]; // RQ3
                `TMR3_OFS_CM2: cm2_ff <= pwdata_in[3:0]; // RQ3
                `TMR3_OFS_CO1: co1_ff <= pwdata_in[7:0];
                `TMR3_OFS_CO2: co2_ff <= pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // mode decode and counter clock
    assign m_trig = (mode_ff == tmr3_pkg::TMR3_M2) | (mode_ff == tmr3_pkg::TMR3_M5); // RQ15
    assign m_t2trig = (mode_ff == tmr3_pkg::TMR3_M3) | (mode_ff == tmr3_pkg::TMR3_M9);
    assign m_so = (mode_ff == tmr3_pkg::TMR3_M8) | (mode_ff == tmr3_pkg::TMR3_M9); // RQ18 RQ19
    assign m_dem = (mode_ff == tmr3_pkg::TMR3_M10) | (mode_ff == tmr3_pkg::TMR3_M11);
    assign t2tog = second_timer_output_flipflop_in ^ m2_prev_ff;

    // clock source select, external and timer ticks as edge pulses
    always_comb begin
        unique case (tmr3_pkg::tmr3_clk_t'(csel_ff[1:0]))
            tmr3_pkg::TMR3_CK_SYS: tick = 1'b1; // RQ26
            tmr3_pkg::TMR3_CK_T2: tick = second_timer_out_in & ~t2_prev_ff; // RQ26
            tmr3_pkg::TMR3_CK_T1: tick = first_timer_out_in & ~t1_prev_ff; // RQ26
            tmr3_pkg::TMR3_CK_EXT: tick = ext_edge; // RQ26 RQ12
        endcase
    end

    // ==========================================
    // compare selection and match
    assign go = ~(m_trig & wait_ff); // RQ13
    assign cur_sel = m_so ? serial_data_in : sel_ff; // RQ18 RQ19
    assign cmp_val = cur_sel ? co2_ff : co1_ff;
    assign cm_cur = cur_sel ? cm2_ff : cm1_ff;
    // equal at x gives a period of x+1 ticks
    assign hit = run_ff & go & tick & (cnt_ff == cmp_val)
        & ~(cur_sel ? done2_ff : done1_ff); // RQ11 RQ4
    assign hit1 = hit & ~cur_sel;
    assign hit2 = hit & cur_sel;
    assign restart = run_ff & ((m_trig & ext_edge & ~wait_ff)
        | (m_t2trig & t2tog) | (m_dem & ext_edge & wait_ff)); // RQ13 RQ14 RQ19 RQ20
    assign cap_evt = run_ff & ((m_trig & ext_edge & ~wait_ff)
        | ((mode_ff == tmr3_pkg::TMR3_M3) & t2tog)
        | ((mode_ff == tmr3_pkg::TMR3_M12) & ext_edge)); // RQ13 RQ14 RQ22

    // next compare: alternate unless the other one is spent
    always_comb begin
        nxt_sel = ~cur_sel; // RQ5
        if (cur_sel ? done1_ff : done2_ff) begin
            nxt_sel = cur_sel; // RQ6
        end
    end

    // ==========================================
    // counter, select and single action state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run_ff || restart) begin
            cnt_ff <= 8'h00; // RQ27
            sel_ff <= 1'b0; // RQ5
            done1_ff <= 1'b0; // RQ4
            done2_ff <= 1'b0;
        end else begin
            if (hit && cm_cur[`TMR3_CM_RST]) begin
                cnt_ff <= 8'h00; // RQ3
            end else if (tick && go) begin
                cnt_ff <= cnt_ff + 8'h01; // RQ12
            end
            if (hit) begin
                sel_ff <= nxt_sel;
            end
            if (hit1 && cm1_ff[`TMR3_CM_SGL]) begin
                done1_ff <= 1'b1; // RQ4
            end
            if (hit2 && cm2_ff[`TMR3_CM_SGL]) begin
                done2_ff <= 1'b1; // RQ4
            end
        end
    end

    // trigger wait and biphase mid-frame flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run_ff) begin
            wait_ff <= 1'b1;
            mid_ff <= 1'b0;
        end else begin
            if (ext_edge && wait_ff) begin
                wait_ff <= 1'b0; // RQ13
            end else if (m_dem && hit1) begin
                wait_ff <= 1'b1; // RQ20
            end
            if (ext_edge && !wait_ff) begin
                mid_ff <= 1'b1; // RQ21
            end else if (hit1) begin
                mid_ff <= 1'b0;
            end
        end
    end

    // capture register, follows counter except in modes 2, 3, 5, 9 and 12
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cap_ff <= 8'h00;
        end else if (cap_evt) begin
            cap_ff <= cnt_ff; // RQ13 RQ14 RQ22
        end else if (!m_trig && !m_t2trig && mode_ff != tmr3_pkg::TMR3_M12) begin
            cap_ff <= cnt_ff; // RQ1
        end
    end

    // ==========================================
    // output toggle flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tog_ff <= 1'b0;
        end else if (ctl_wr && !run_ff) begin
            tog_ff <= pwdata_in[`TMR3_CTL_TOP]
                ^ (pwdata_in[`TMR3_CTL_RUN] & pwdata_in[`TMR3_CTL_TS]); // RQ7
        end else if (hit && cm_cur[`TMR3_CM_TOG]) begin
            tog_ff <= ~tog_ff; // RQ3
        end
    end

    // ==========================================
    // status flags, hardware set wins over read clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_c1_ff <= 1'b0;
            st_c2_ff <= 1'b0;
            st_ed_ff <= 1'b0;
        end else begin
            st_c1_ff <= hit1 | (st_c1_ff & ~st_rd); // RQ10 RQ24
            st_c2_ff <= hit2 | (st_c2_ff & ~st_rd); // RQ10 RQ24
            st_ed_ff <= ext_edge | (st_ed_ff & ~st_rd); // RQ10 RQ24
        end
    end

    // ==========================================
    // registered outputs and edge history
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_ff <= 1'b0;
            pin_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sdat_ff <= 1'b0;
            m2_prev_ff <= 1'b0;
            t2_prev_ff <= 1'b0;
            t1_prev_ff <= 1'b0;
        end else begin
            irq_ff <= (hit1 & cm1_ff[`TMR3_CM_IRQ]) | (hit2 & cm2_ff[`TMR3_CM_IRQ])
                | (ext_edge & eim_ff & ~run_ff); // RQ3 RQ9
            sclk_ff <= run_ff & m_dem & hit1; // RQ20 RQ21
            sdat_ff <= (mode_ff == tmr3_pkg::TMR3_M11) ? mid_ff : ext_lvl; // RQ20 RQ21
            m2_prev_ff <= second_timer_output_flipflop_in;
            t2_prev_ff <= second_timer_out_in;
            t1_prev_ff <= first_timer_out_in;
            unique case (mode_ff)
                tmr3_pkg::TMR3_M4, tmr3_pkg::TMR3_M5, tmr3_pkg::TMR3_M10,
                tmr3_pkg::TMR3_M11: pin_ff <= second_timer_out_in; // RQ15
                tmr3_pkg::TMR3_M6: pin_ff <= tog_ff & second_timer_output_flipflop_in; // RQ16
                tmr3_pkg::TMR3_M7: pin_ff <= tog_ff & serial_data_in; // RQ17
                default: pin_ff <= tog_ff;
            endcase
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign timer_output_pin_out = pin_ff;
    assign timer_irq_out = irq_ff;
    assign shift_clk_out = sclk_ff;
    assign shift_data_out = sdat_ff;

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_edge_stopped;
        ext_edge && eim_ff && !run_ff;
    endsequence
    sequence s_hit_rst;
        hit && cm_cur[`TMR3_CM_RST];
    endsequence

    AST_STOP_CLEARS: assert property (!run_ff |=> cnt_ff == 8'h00 && !sel_ff) // RQ27
        else $error("counter not cleared while stopped");
    AST_MATCH_RESET: assert property (s_hit_rst |=> cnt_ff == 8'h00) // RQ3
        else $error("reset mask ignored on match");
    AST_EDGE_IRQ: assert property (s_edge_stopped |=> timer_irq_out) // RQ9
        else $error("edge interrupt missing");
    AST_EDGE_FLAG: assert property (ext_edge |=> st_ed_ff) // RQ10
        else $error("edge flag not set");
    AST_READ_CLR: assert property (st_rd && !hit && !ext_edge |=> !st_c1_ff && !st_c2_ff
        && !st_ed_ff) // RQ24
        else $error("status read did not clear");
    AST_ALTERNATE: assert property (hit1 && !m_so && !restart && !done2_ff |=> sel_ff) // RQ5
        else $error("compare did not alternate");
    AST_SINGLE: assert property (hit1 && cm1_ff[`TMR3_CM_SGL] && !restart |=> done1_ff
        ##0 (!hit1)[*2]) // RQ4
        else $error("single action repeated");
    AST_CAP_M3: assert property (cap_evt |=> cap_ff == $past(cnt_ff)) // RQ14
        else $error("capture value wrong");
    AST_MODE_LEGAL: assert property (mode_ff >= `TMR3_MODE_MIN) // RQ23
        else $error("illegal mode code held");
    AST_GATE_M6: assert property (mode_ff == tmr3_pkg::TMR3_M6
        && !second_timer_output_flipflop_in |=> !timer_output_pin_out) // RQ16
        else $error("carrier not gated");
    AST_SHIFT_M10: assert property (m_dem && hit1 |=> shift_clk_out ##1 !shift_clk_out) // RQ20
        else $error("shift pulse wrong");
endmodule
`default_nettype wire

// ==== tmr3_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: timer 2, timer 1 and serial unit
module tmr3_far_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic m2_toggle_in,
    input wire logic m2_level_in,
    input wire logic t2_run_in,
    input wire logic t2_level_in,
    input wire logic so_level_in,
    input wire logic shift_clk_in,
    input wire logic shift_data_in,
    output logic m2_out,
    output logic t2_out,
    output logic t1_out,
    output logic so_out,
    output logic [7:0] shift_reg_out
);
    logic [4:0] m2_cnt_ff;
    logic [2:0] t1_cnt_ff, t2_cnt_ff;
    logic m2_ff;
    logic [7:0] sr_ff;
    // timer 2 toggle flop: toggles every 20 cycles or holds a level
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            m2_cnt_ff <= 5'h0;
            m2_ff <= 1'b0;
        end else if (m2_toggle_in) begin
            m2_cnt_ff <= (m2_cnt_ff == 5'h13) ? 5'h0 : m2_cnt_ff + 5'h1;
            m2_ff <= (m2_cnt_ff == 5'h13) ? ~m2_ff : m2_ff;
        end else begin
            m2_cnt_ff <= 5'h0;
            m2_ff <= m2_level_in;
        end
    end
    // free running output clocks, periods 4 and 6
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            t1_cnt_ff <= 3'h0;
            t2_cnt_ff <= 3'h0;
        end else begin
            t1_cnt_ff <= (t1_cnt_ff == 3'h3) ? 3'h0 : t1_cnt_ff + 3'h1;
            t2_cnt_ff <= (t2_cnt_ff == 3'h5) ? 3'h0 : t2_cnt_ff + 3'h1;
        end
    end
    assign t1_out = (t1_cnt_ff < 3'h2);
    assign t2_out = t2_run_in ? (t2_cnt_ff < 3'h3) : t2_level_in;
    assign so_out = so_level_in;
    assign m2_out = m2_ff;
    // serial shift register fed by the decoder
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sr_ff <= 8'h0;
        end else if (shift_clk_in) begin
            sr_ff <= {sr_ff[6:0], shift_data_in};
        end
    end
    assign shift_reg_out = sr_ff;
endmodule
`default_nettype wire

// ==== test_timer3_mod_demod_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_regs.svh"
// ==========================================
// bench for the third timer
module test_timer3_mod_demod_counter;
    logic clk, rst_n, psel, pen, pwr, pready, perr, irq, pin, pin_q, sclk, sdat;
    logic ext, ext_auto, ext_rnd, m2_tog, m2_lvl, t2_run, t2_lvl, so_lvl, m2, t2, t1, so;
    logic [7:0] paddr, sr, exp_sr;
    logic [31:0] pwdata, prdata;
    logic [32:0] rq[$];
    int iq[$];
    int bad_count, checks_done, cyc, last, irq_n, tr_n, ecnt, eper, n0, e, i, k, seed;
    int pers[3] = '{12, 18, 15};

    tmr3_top dut (
        .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .external_timer_in(ext),
        .second_timer_output_flipflop_in(m2), .second_timer_out_in(t2),
        .first_timer_out_in(t1), .serial_data_in(so), .timer_output_pin_out(pin),
        .timer_irq_out(irq), .shift_clk_out(sclk), .shift_data_out(sdat)
    );
    tmr3_far_model far (
        .clk_in(clk), .rst_n_in(rst_n), .m2_toggle_in(m2_tog), .m2_level_in(m2_lvl),
        .t2_run_in(t2_run), .t2_level_in(t2_lvl), .so_level_in(so_lvl),
        .shift_clk_in(sclk), .shift_data_in(sdat), .m2_out(m2), .t2_out(t2),
        .t1_out(t1), .so_out(so), .shift_reg_out(sr)
    );

    // clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================
    // shared tasks
    task chk(input logic [32:0] seen, input logic [32:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task stop_test;
        $display("checks=%0d bad=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready, then one idle edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] x);
        rq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    task cfg(input logic [3:0] md, cs, c1, c2, input logic [7:0] o1, o2);
        wr(`TMR3_OFS_MODE, 32'(md));
        wr(`TMR3_OFS_CSEL, 32'(cs));
        wr(`TMR3_OFS_CM1, 32'(c1));
        wr(`TMR3_OFS_CM2, 32'(c2));
        wr(`TMR3_OFS_CO1, 32'(o1));
        wr(`TMR3_OFS_CO2, 32'(o2));
    endtask
    task burst(input logic [31:0] c);
        wr(`TMR3_OFS_CTRL, c);
        while (iq.size() > 0) @(posedge clk);
        wr(`TMR3_OFS_CTRL, 32'h0);
    endtask
    task gap(input int n);
        repeat (n) @(posedge clk);
    endtask

    // watcher: read data, interrupt spacing, pin edges, timeout
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr)
            chk({perr, prdata}, rq.pop_front());
        if (pin !== pin_q) tr_n++;
        pin_q = pin;
        if (irq === 1'b1) begin
            irq_n++;
            if (iq.size() > 0) begin
                e = iq.pop_front();
                if (e >= 0) chk(33'(cyc - last), 33'(e));
            end
            last = cyc;
        end
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // external input toggler, fixed or random spacing
    always @(posedge clk) begin
        if (ext_auto) begin
            if (ecnt + 1 >= eper) begin
                ecnt <= 0;
                ext <= ~ext;
                exp_sr <= {exp_sr[6:0], ~ext};
                if (ext_rnd) eper <= 12 + ($random(seed) & 7);
            end else begin
                ecnt <= ecnt + 1;
            end
        end
    end

    // ==========================================
    // main sequence
    initial begin
        seed = 32'h8c3b;
        {psel, pen, pwr, ext, ext_auto, ext_rnd, m2_tog, m2_lvl, t2_lvl, so_lvl} = '0;
        t2_run = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        exp_sr = 8'h0;
        eper = 5;
        rst_n = 1'b0;
        gap(20);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values, refused writes, unmapped place
        rd(`TMR3_OFS_MODE, 33'hf);
        rd(`TMR3_OFS_CSEL, 33'hf);
        rd(`TMR3_OFS_CM1, 33'h0);
        rd(`TMR3_OFS_CO2, 33'hff);
        rd(`TMR3_OFS_CAP, 33'h0);
        rd(`TMR3_OFS_STAT, 33'h0);
        for (i = 0; i < 4; i++) wr(`TMR3_OFS_MODE, 32'(i));
        wr(8'h24, 32'h5);
        rd(`TMR3_OFS_MODE, 33'hf);
        rd(8'h24, 33'h1_0000_0000);
        // alternating compares, then flags read and cleared
        cfg(4'hf, 4'hf, 4'h3, 4'h3, 8'h2, 8'h4);
        iq = '{-1, 5, 3, 5, 3};
        burst(32'h1);
        rd(`TMR3_OFS_STAT, 33'h3);
        rd(`TMR3_OFS_STAT, 33'h0);
        // single action on compare one, started twice
        cfg(4'hf, 4'hf, 4'h9, 4'h3, 8'h2, 8'h4);
        for (i = 0; i < 2; i++) begin
            iq = '{-1, 2, 5, 5};
            burst(32'h1);
        end
        // serial level picks the compare
        for (i = 0; i < 2; i++) begin
            so_lvl <= i[0];
            cfg(4'h8, 4'hf, 4'h7, 4'h7, 8'h2, 8'h4);
            iq = '{-1, 3 + 2 * i, 3 + 2 * i, 3 + 2 * i};
            burst(32'h1);
        end
        so_lvl <= 1'b0;
        // clock sources: timer 1, timer 2, external edges
        ext_auto <= 1'b1;
        for (i = 0; i < 3; i++) begin
            cfg(4'hf, 4'((i + 1) % 3), 4'h3, 4'h3, 8'h2, 8'h2);
            iq = '{-1, pers[i], pers[i]};
            burst(32'h1);
        end
        ext_auto <= 1'b0;
        gap(1);
        ext <= 1'b0;
        gap(8);
        rd(`TMR3_OFS_STAT, 33'h7);
        // edge interrupt per edge select, only while stopped
        cfg(4'hf, 4'hf, 4'h0, 4'h0, 8'hff, 8'hff);
        for (i = 0; i < 3; i++) begin
            k = 2 - i;
            wr(`TMR3_OFS_CSEL, 32'(k * 4 + 3));
            wr(`TMR3_OFS_CTRL, 32'h8);
            n0 = irq_n;
            ext <= 1'b1;
            gap(8);
            chk(33'(irq_n - n0), 33'(k != 1));
            n0 = irq_n;
            ext <= 1'b0;
            gap(8);
            chk(33'(irq_n - n0), 33'(k != 2));
        end
        wr(`TMR3_OFS_CTRL, 32'h9);
        n0 = irq_n;
        ext <= 1'b1;
        gap(8);
        ext <= 1'b0;
        gap(8);
        chk(33'(irq_n - n0), 33'h0);
        wr(`TMR3_OFS_CTRL, 32'h0);
        rd(`TMR3_OFS_STAT, 33'h4);
        // output preset while stopped
        wr(`TMR3_OFS_CTRL, 32'h4);
        gap(3);
        chk({32'h0, pin}, 33'h1);
        wr(`TMR3_OFS_CTRL, 32'h0);
        gap(3);
        chk({32'h0, pin}, 33'h0);
        // external and timer 2 triggered capture
        ext_auto <= 1'b1;
        for (i = 0; i < 2; i++) begin
            eper <= 30 - 4 * i;
            cfg(i ? 4'hb : 4'he, 4'h3, 4'h0, 4'h0, 8'hff, 8'hff);
            wr(`TMR3_OFS_CTRL, 32'h1);
            gap(100);
            rd(`TMR3_OFS_CAP, 33'(29 - 4 * i));
            wr(`TMR3_OFS_CTRL, 32'h0);
        end
        ext_auto <= 1'b0;
        m2_tog <= 1'b1;
        cfg(4'hd, 4'hf, 4'h0, 4'h0, 8'hff, 8'hff);
        wr(`TMR3_OFS_CTRL, 32'h1);
        gap(100);
        rd(`TMR3_OFS_CAP, 33'h13);
        wr(`TMR3_OFS_CTRL, 32'h0);
        m2_tog <= 1'b0;
        // timer 2 signal routed to the pin
        cfg(4'hc, 4'hf, 4'h0, 4'h0, 8'hff, 8'hff);
        t2_run <= 1'b0;
        t2_lvl <= 1'b1;
        gap(6);
        chk({32'h0, pin}, 33'h1);
        t2_lvl <= 1'b0;
        gap(6);
        chk({32'h0, pin}, 33'h0);
        t2_run <= 1'b1;
        // carrier gated by toggle flop, then by serial data
        for (i = 0; i < 2; i++) begin
            cfg(i ? 4'h9 : 4'ha, 4'hf, 4'h6, 4'h6, 8'h2, 8'h2);
            wr(`TMR3_OFS_CTRL, 32'h1);
            for (k = 0; k < 2; k++) begin
                m2_lvl <= k[0] ^ i[0];
                so_lvl <= k[0] ^ !i[0];
                gap(10);
                n0 = tr_n;
                gap(30);
                chk(33'(tr_n - n0), 33'(k * 10));
            end
            wr(`TMR3_OFS_CTRL, 32'h0);
        end
        // edge decoders, manchester then biphase, random spacing
        for (i = 0; i < 2; i++) begin
            cfg(i ? 4'h5 : 4'h6, 4'h3, 4'h0, 4'h0, 8'h5, 8'hff);
            wr(`TMR3_OFS_CTRL, 32'h1);
            ext_rnd <= 1'b1;
            ecnt <= 0;
            eper <= 15;
            ext_auto <= 1'b1;
            gap(200);
            ext_auto <= 1'b0;
            gap(40);
            chk(33'(sr[3:0]), i ? 33'h0 : 33'(exp_sr[3:0]));
            wr(`TMR3_OFS_CTRL, 32'h0);
        end
        stop_test();
    end
endmodule
`default_nettype wire
